//--- shared/rbp_pkg.sv
// constants for the second-reference loop profile register bank
`default_nettype none
package rbp_pkg;
  // bus widths
  localparam int ADDR_W = 16; // register address width
  localparam int DATA_W = 8; // register data width
  // register byte addresses
  localparam logic [15:0] BASE_ADDR = 16'h044d; // first profile register
  localparam logic [15:0] PRIORITY_ENABLE_ADDR = 16'h044d; // priority and enable
  localparam logic [15:0] BANDWIDTH_LOW_ADDR = 16'h044e; // bandwidth bits 7:0
  localparam logic [15:0] BANDWIDTH_MID_ADDR = 16'h044f; // bandwidth bits 15:8
  localparam logic [15:0] BANDWIDTH_HIGH_FILTER_ADDR = 16'h0450; // bandwidth bit 16, filter
  localparam logic [15:0] INT_DIVIDER_LOW_ADDR = 16'h0451; // divider bits 7:0
  localparam logic [15:0] INT_DIVIDER_MID_ADDR = 16'h0452; // divider bits 15:8
  localparam logic [15:0] INT_DIVIDER_HIGH_ADDR = 16'h0453; // divider bits 17:16
  localparam logic [15:0] FRAC_NUMERATOR_LOW_ADDR = 16'h0454; // numerator bits 7:0
  localparam logic [15:0] FRAC_NUMERATOR_MID_ADDR = 16'h0455; // numerator bits 15:8
  localparam logic [15:0] FRAC_NUMERATOR_HIGH_ADDR = 16'h0456; // numerator bits 23:16
  localparam logic [15:0] FRAC_MODULUS_LOW_ADDR = 16'h0457; // modulus bits 7:0
  localparam logic [15:0] FRAC_MODULUS_MID_ADDR = 16'h0458; // modulus bits 15:8
  localparam logic [15:0] FRAC_MODULUS_HIGH_ADDR = 16'h0459; // modulus bits 23:16
  localparam logic [15:0] LAST_ADDR = 16'h0459; // last profile register
  localparam logic [15:0] STATUS_ADDR = 16'h0480; // read-only commit status
  // bank shape
  localparam int NUM_REGS = 13; // byte registers in the profile
  localparam int NUM_GROUPS = 4; // multi-byte fields committed as a whole
  localparam int GROUP_W = 24; // three bytes per group
  localparam int IDX_W = 4; // register index width
  // field positions
  localparam int ENABLE_BIT = 0; // loop may lock to the reference
  localparam int PRIO_LSB = 1; // priority low bit
  localparam int PRIO_MSB = 2; // priority high bit
  localparam int BW_W = 17; // bandwidth factor width, 0.1 Hz units
  localparam int FILTER_POS = 17; // filter select inside bandwidth group
  localparam int DIV_W = 18; // integer divider width, stored minus one
  localparam int FRAC_W = 24; // numerator and modulus width
  // group numbering
  localparam int GRP_BW = 0; // bandwidth and filter
  localparam int GRP_DIV = 1; // integer divider
  localparam int GRP_NUM = 2; // fractional numerator
  localparam int GRP_MOD = 3; // fractional modulus
  // writable bit masks
  localparam logic [7:0] MASK_PRIO = 8'h07; // priority register
  localparam logic [7:0] MASK_TOP2 = 8'h03; // two-bit top registers
  localparam logic [7:0] MASK_FULL = 8'hff; // full byte registers
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00; // every profile register
  localparam logic [23:0] RESET_GROUP = 24'h000000; // committed fields
  localparam logic RESET_BYPASS = 1'b1; // modulus resets to zero
  // status register layout
  localparam int STAT_BYPASS_BIT = 0; // fractional divider bypassed
  localparam int STAT_PEND_LSB = 1; // per-group uncommitted bytes
endpackage : rbp_pkg
`default_nettype wire

//--- verilog/rbp_shadow.sv
// committed copy of one multi-byte profile field
`default_nettype none
module rbp_shadow #(
  parameter int WIDTH = 24, // field width
  parameter logic [23:0] RESET_VALUE = 24'h000000 // value after reset
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic ce, // clock enable
  input wire logic load, // commit pulse
  input wire logic [WIDTH-1:0] d, // staged field value
  output logic [WIDTH-1:0] q // value the loop sees
);
  // refuse widths the reset constant cannot cover
  if (WIDTH > 24 || WIDTH < 1) begin : g_chk
    $error("rbp_shadow width out of range");
  end

  // loop value changes only on a whole-field commit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET_VALUE[WIDTH-1:0];
    end else if (ce && load) begin
      q <= d;
    end
  end
endmodule : rbp_shadow
`default_nettype wire

//--- verilog/rbp_regs.sv
// loop profile register bank for the second reference input
//
// Added by the designer: strobed register access.
`default_nettype none
// Operation
// - two-bit priority in bits 2:1, 00 highest
// - bit 0 enables locking, reset forbids
// - 17-bit bandwidth factor, low byte first
// - bit 1 selects high phase margin filter
// - 18-bit integer divider, stored ratio minus one
// - 24-bit fractional numerator, low byte first
// - 24-bit fractional modulus, low byte first
// - zero modulus bypasses the fractional divider
module rbp_regs #(
  parameter int ADDR_W = 16 // register address width
) (
  input wire logic clk, // system clock, 25 MHz
  input wire logic resetn, // asynchronous reset, active low
  input wire logic ce, // clock enable, freezes all state but the reset synchroniser when low
  input wire logic [ADDR_W-1:0] addr, // register byte address
  input wire logic [7:0] wr_data, // write data
  input wire logic wr_en, // write strobe, one cycle
  input wire logic rd_en, // read strobe, one cycle
  output logic [7:0] rd_data, // read data, cycle after the strobe
  output logic [1:0] ref_priority, // selection priority, 0 highest
  output logic ref_enable, // loop may lock to this reference
  output logic [16:0] loop_bandwidth, // bandwidth factor, 0.1 Hz units
  output logic high_margin_filter, // high phase margin base filter
  output logic [17:0] integer_feedback_divider, // divide ratio minus one
  output logic [23:0] fractional_numerator, // fractional numerator
  output logic [23:0] fractional_modulus, // fractional modulus
  output logic frac_bypass // fractional divider disabled
);
  // addresses above the decoder width cannot be served
  if (ADDR_W < 11 || ADDR_W > 16) begin : g_chk
    $error("rbp_regs address width must be 11 to 16 bits");
  end

  // reset release synchroniser
  logic [1:0] rst_sync_reg; // two-stage release shifter
  logic rst_n; // synchronised reset used by the bank

  // staging and decode
  logic [7:0] stage_reg [0:rbp_pkg::NUM_REGS-1]; // software-visible bytes
  logic [15:0] addr_ext; // address widened to sixteen bits
  logic in_bank; // address falls in the profile range
  logic [rbp_pkg::IDX_W-1:0] reg_idx; // register index inside the bank
  logic wr_hit; // write to a profile register
  logic rd_hit; // read from a profile register
  logic rd_stat; // read from the status register

  // commit machinery
  logic [rbp_pkg::NUM_GROUPS-1:0] commit; // top byte of a group written
  logic [rbp_pkg::NUM_GROUPS-1:0] pending_reg; // low bytes written, not yet committed
  logic [rbp_pkg::GROUP_W-1:0] load_val [0:rbp_pkg::NUM_GROUPS-1]; // whole staged field
  logic [rbp_pkg::GROUP_W-1:0] group_q [0:rbp_pkg::NUM_GROUPS-1]; // committed fields
  logic frac_bypass_reg; // modulus committed as zero
  logic [7:0] rd_data_reg; // read data flop
  logic [7:0] rd_data_next; // read data next value
  logic [7:0] status_val; // assembled status byte

  // writable mask per register, reserved bits stay zero
  function automatic logic [7:0] reg_mask(input int idx);
    logic [7:0] m;
    m = rbp_pkg::MASK_FULL;
    if (idx == 0) begin
      m = rbp_pkg::MASK_PRIO;
    end else if (idx == 3 || idx == 6) begin
      m = rbp_pkg::MASK_TOP2;
    end
    return m;
  endfunction : reg_mask

  // release reset through two flops, assert at once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // address decode; bus is on our clock, no synchroniser needed
  always_comb begin
    addr_ext = 16'h0000;
    addr_ext[ADDR_W-1:0] = addr;
  end
  assign in_bank = (addr_ext >= rbp_pkg::BASE_ADDR) && (addr_ext <= rbp_pkg::LAST_ADDR);
  assign reg_idx = rbp_pkg::IDX_W'(addr_ext - rbp_pkg::BASE_ADDR);
  assign wr_hit = wr_en && in_bank;
  assign rd_hit = rd_en && in_bank;
  assign rd_stat = rd_en && (addr_ext == rbp_pkg::STATUS_ADDR);

  // staging bytes, one flop group per register
  for (genvar i = 0; i < rbp_pkg::NUM_REGS; i++) begin : g_byte
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        stage_reg[i] <= rbp_pkg::RESET_BYTE; // enable off after reset
      end else if (ce && wr_hit && reg_idx == rbp_pkg::IDX_W'(i)) begin
        stage_reg[i] <= wr_data & reg_mask(i);
      end
    end
  end

  // priority and enable are single-byte, so they act directly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_priority <= 2'h0;
      ref_enable <= 1'b0;
    end else if (ce && wr_hit && reg_idx == rbp_pkg::IDX_W'(0)) begin
      ref_priority <= wr_data[rbp_pkg::PRIO_MSB:rbp_pkg::PRIO_LSB];
      ref_enable <= wr_data[rbp_pkg::ENABLE_BIT];
    end
  end

  // per-group commit: writing the top byte moves the whole field to the loop
  for (genvar g = 0; g < rbp_pkg::NUM_GROUPS; g++) begin : g_group
    localparam int LO = 3 * g + 1; // low byte index
    localparam int MI = 3 * g + 2; // middle byte index
    localparam int HI = 3 * g + 3; // top byte index

    // top byte taken from the bus so the commit carries the new value
    assign commit[g] = wr_hit && (reg_idx == rbp_pkg::IDX_W'(HI));
    assign load_val[g] = {wr_data & reg_mask(HI), stage_reg[MI], stage_reg[LO]};

    // pending marks a half-written field; a commit always clears it
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pending_reg[g] <= 1'b0;
      end else if (ce) begin
        if (commit[g]) begin
          pending_reg[g] <= 1'b0;
        end else if (wr_hit && (reg_idx == rbp_pkg::IDX_W'(LO) ||
                                reg_idx == rbp_pkg::IDX_W'(MI))) begin
          pending_reg[g] <= 1'b1;
        end
      end
    end

    // committed field held apart from the staging bytes
    rbp_shadow #(
      .WIDTH(rbp_pkg::GROUP_W),
      .RESET_VALUE(rbp_pkg::RESET_GROUP)
    ) u_shadow (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .load(commit[g]),
      .d(load_val[g]),
      .q(group_q[g])
    );
  end

  // slice committed groups into the loop-facing fields
  assign loop_bandwidth = group_q[rbp_pkg::GRP_BW][rbp_pkg::BW_W-1:0];
  assign high_margin_filter = group_q[rbp_pkg::GRP_BW][rbp_pkg::FILTER_POS];
  assign integer_feedback_divider = group_q[rbp_pkg::GRP_DIV][rbp_pkg::DIV_W-1:0];
  assign fractional_numerator = group_q[rbp_pkg::GRP_NUM][rbp_pkg::FRAC_W-1:0];
  assign fractional_modulus = group_q[rbp_pkg::GRP_MOD][rbp_pkg::FRAC_W-1:0];

  // bypass follows the committed modulus, decided at the same edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frac_bypass_reg <= rbp_pkg::RESET_BYPASS; // modulus resets to zero
    end else if (ce && commit[rbp_pkg::GRP_MOD]) begin
      frac_bypass_reg <= (load_val[rbp_pkg::GRP_MOD] == rbp_pkg::RESET_GROUP);
    end
  end
  assign frac_bypass = frac_bypass_reg;

  // status byte: bypass plus per-group pending flags
  always_comb begin
    status_val = 8'h00;
    status_val[rbp_pkg::STAT_BYPASS_BIT] = frac_bypass_reg;
    status_val[rbp_pkg::STAT_PEND_LSB +: rbp_pkg::NUM_GROUPS] = pending_reg;
  end

  // read mux; staged bytes read back, unmapped reads return zero
  always_comb begin
    rd_data_next = 8'h00;
    if (rd_hit) begin
      rd_data_next = stage_reg[reg_idx];
    end else if (rd_stat) begin
      rd_data_next = status_val;
    end
  end

  // read data stands one cycle only, zero otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= 8'h00;
    end else if (ce) begin
      rd_data_reg <= rd_data_next;
    end
  end
  assign rd_data = rd_data_reg;

  // note: a zero bandwidth factor or one above detector rate/20 is passed
  // through unchecked; keeping it sane is software's job
endmodule : rbp_regs
`default_nettype wire

//--- dv/rbp_regs_assertions.sv
// concurrent checks on the profile register bank ports
`default_nettype none
module rbp_regs_assertions #(
  parameter int ADDR_W = 16 // register address width
) (
  input wire logic clk, // system clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic [ADDR_W-1:0] addr, // register byte address
  input wire logic [7:0] wr_data, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  input wire logic [7:0] rd_data, // read data
  input wire logic [1:0] ref_priority, // selection priority
  input wire logic ref_enable, // lock enable
  input wire logic [16:0] loop_bandwidth, // bandwidth factor
  input wire logic high_margin_filter, // filter select
  input wire logic [17:0] integer_feedback_divider, // divider minus one
  input wire logic [23:0] fractional_numerator, // numerator
  input wire logic [23:0] fractional_modulus, // modulus
  input wire logic frac_bypass // fractional divider off
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // a write of one address, taken this cycle
  sequence s_wr(logic [15:0] a);
    ce && wr_en && addr == a;
  endsequence
  // three back-to-back modulus bytes, low first
  sequence s_mod_burst;
    s_wr(rbp_pkg::FRAC_MODULUS_LOW_ADDR) ##1 s_wr(rbp_pkg::FRAC_MODULUS_MID_ADDR)
      ##1 s_wr(rbp_pkg::FRAC_MODULUS_HIGH_ADDR);
  endsequence
  property p_rd_idle; ce && !rd_en |=> rd_data == 8'h00; endproperty
  property p_prio; s_wr(rbp_pkg::PRIORITY_ENABLE_ADDR) |=>
    ref_priority == $past(wr_data[2:1]) && ref_enable == $past(wr_data[0]); endproperty
  property p_bypass; frac_bypass == (fractional_modulus == 24'h000000); endproperty
  property p_bw_stage; s_wr(rbp_pkg::BANDWIDTH_LOW_ADDR) |=> $stable(loop_bandwidth); endproperty
  property p_bw_top; s_wr(rbp_pkg::BANDWIDTH_HIGH_FILTER_ADDR) |=>
    loop_bandwidth[16] == $past(wr_data[0]) && high_margin_filter == $past(wr_data[1]);
  endproperty
  property p_div_top; s_wr(rbp_pkg::INT_DIVIDER_HIGH_ADDR) |=>
    integer_feedback_divider[17:16] == $past(wr_data[1:0]); endproperty
  property p_num_top; s_wr(rbp_pkg::FRAC_NUMERATOR_HIGH_ADDR) |=>
    fractional_numerator[23:16] == $past(wr_data); endproperty
  property p_mod_whole; s_mod_burst |=>
    fractional_modulus == {$past(wr_data), $past(wr_data, 2), $past(wr_data, 3)}; endproperty
  property p_div_hold; !(ce && wr_en) |=> $stable(integer_feedback_divider); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  a_prio: assert property (p_prio) else $error("priority or enable wrong");
  a_bypass: assert property (p_bypass) else $error("bypass flag wrong");
  a_bw_stage: assert property (p_bw_stage) else $error("bandwidth moved early");
  a_bw_top: assert property (p_bw_top) else $error("bandwidth top wrong");
  a_div_top: assert property (p_div_top) else $error("divider top wrong");
  a_num_top: assert property (p_num_top) else $error("numerator top wrong");
  a_mod_whole: assert property (p_mod_whole) else $error("modulus wrong");
  a_div_hold: assert property (p_div_hold) else $error("divider changed");
endmodule : rbp_regs_assertions
bind rbp_regs rbp_regs_assertions #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .resetn(resetn),
  .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .ref_priority(ref_priority), .ref_enable(ref_enable), .loop_bandwidth(loop_bandwidth),
  .high_margin_filter(high_margin_filter), .integer_feedback_divider(integer_feedback_divider),
  .fractional_numerator(fractional_numerator), .fractional_modulus(fractional_modulus),
  .frac_bypass(frac_bypass));
`default_nettype wire

//--- dv/rbp_regs_bench.sv
// register-level bench for the profile register bank
`default_nettype none
module rbp_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0; // 25 MHz
  logic resetn = 1'b0; // active low
  logic ce = 1'b1; // held on except once, to check that a write is swallowed
  logic [15:0] addr = 16'h0000; // byte address
  logic [7:0] wr_data = 8'h00; // write data
  logic wr_en = 1'b0; // write strobe
  logic rd_en = 1'b0; // read strobe
  logic [7:0] rd_data; // read data
  logic [1:0] prio; // priority output
  logic en; // enable output
  logic [16:0] bw; // bandwidth output
  logic filt; // filter output
  logic [17:0] div; // divider output
  logic [23:0] num; // numerator output
  logic [23:0] modu; // modulus output
  logic byp; // bypass output
  int n_errors = 0; // mismatches
  int n_tests = 0; // comparisons
  int cycles = 0; // timeout counter
  rbp_regs #(.ADDR_W(16)) uut (.clk(clk), .resetn(resetn), .ce(ce), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ref_priority(prio),
    .ref_enable(en), .loop_bandwidth(bw), .high_margin_filter(filt),
    .integer_feedback_divider(div), .fractional_numerator(num), .fractional_modulus(modu),
    .frac_bypass(byp));
  always #20 clk = ~clk;
  // closing report
  task test_done;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // hang guard, whole run needs under a hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      test_done();
    end
  end
  // compare, zero-extended to the widest field
  task chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write; strobe stays up so writes may follow back to back
  task wr(input logic [15:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask : wr
  // drop strobes for one cycle
  task idle;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask : idle
  // one-cycle read, data looked at in the following cycle only
  task rd(input logic [15:0] a, input logic [7:0] exp);
    addr <= a;
    rd_en <= 1'b1;
    wr_en <= 1'b0;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
  endtask : rd
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 13; i++) rd(rbp_pkg::BASE_ADDR + 16'(i), 8'h00);
    idle();
    chk(byp, 24'h1);
    wr(rbp_pkg::PRIORITY_ENABLE_ADDR, 8'hff);
    idle();
    chk({prio, en}, 24'h7);
    rd(rbp_pkg::PRIORITY_ENABLE_ADDR, 8'h07);
    wr(rbp_pkg::PRIORITY_ENABLE_ADDR, 8'h02);
    idle();
    chk({prio, en}, 24'h2);
    wr(rbp_pkg::BANDWIDTH_LOW_ADDR, 8'h34);
    wr(rbp_pkg::BANDWIDTH_MID_ADDR, 8'h12);
    idle();
    chk(bw, 24'h0);
    rd(rbp_pkg::STATUS_ADDR, 8'h03);
    wr(rbp_pkg::BANDWIDTH_HIGH_FILTER_ADDR, 8'hff);
    wr(rbp_pkg::INT_DIVIDER_LOW_ADDR, 8'hcd);
    wr(rbp_pkg::INT_DIVIDER_MID_ADDR, 8'hab);
    wr(rbp_pkg::INT_DIVIDER_HIGH_ADDR, 8'hfe);
    wr(rbp_pkg::FRAC_NUMERATOR_LOW_ADDR, 8'h56);
    wr(rbp_pkg::FRAC_NUMERATOR_MID_ADDR, 8'h34);
    wr(rbp_pkg::FRAC_NUMERATOR_HIGH_ADDR, 8'h12);
    wr(rbp_pkg::FRAC_MODULUS_LOW_ADDR, 8'h01);
    wr(rbp_pkg::FRAC_MODULUS_MID_ADDR, 8'h00);
    wr(rbp_pkg::FRAC_MODULUS_HIGH_ADDR, 8'h00);
    wr(rbp_pkg::STATUS_ADDR, 8'hff);
    idle();
    chk({filt, bw}, 24'h31234);
    chk(div, 24'h2abcd);
    chk(num, 24'h123456);
    chk(modu, 24'h000001);
    chk(byp, 24'h0);
    rd(rbp_pkg::BANDWIDTH_HIGH_FILTER_ADDR, 8'h03);
    rd(rbp_pkg::INT_DIVIDER_HIGH_ADDR, 8'h02);
    rd(rbp_pkg::STATUS_ADDR, 8'h00);
    rd(16'h0500, 8'h00);
    wr(rbp_pkg::FRAC_MODULUS_LOW_ADDR, 8'h00);
    wr(rbp_pkg::FRAC_MODULUS_HIGH_ADDR, 8'h00);
    idle();
    chk(modu, 24'h000000);
    chk(byp, 24'h1);
    // clock enable low must swallow a write to the priority register
    ce <= 1'b0;
    wr(rbp_pkg::PRIORITY_ENABLE_ADDR, 8'h07);
    idle();
    ce <= 1'b1;
    idle();
    chk({prio, en}, 24'h2);
    test_done();
  end
endmodule : rbp_regs_bench
`default_nettype wire
